//--- src/dcgm_monitor.sv
// Dual-channel guard monitor with reset interlock and safety output switch.
`timescale 1ns/1ps
`include "dcgm_params.svh"
module dcgm_monitor #(
    parameter int DEB_CYCLES   = `DCGM_DEB_CYCLES,
    parameter int SHORT_CYCLES = `DCGM_SHORT_CYCLES,
    parameter int DISC_CYCLES  = `DCGM_RESP_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               compl_mode,
    input  wire logic               auto_reset,
    input  wire logic               reset_req,
    input  wire logic               open_window,
    input  wire dcgm_pkg::dcgm_chan_t chan_in,
    output logic                    safety_output_switch,
    output dcgm_pkg::dcgm_fault_t   fault,
    output logic                    reset_enabled,
    output logic                    reset_refused
);
    import dcgm_pkg::*;

    localparam int SW = $clog2(SHORT_CYCLES + 1);
    localparam int DW = $clog2(DISC_CYCLES + 1);

    wire dcgm_chan_t deb;
    logic        a_closed;
    logic        b_closed;
    logic        guard_run;
    logic        any_open;
    logic        both_open;
    logic        both_closed;
    dcgm_state_t st_q;
    dcgm_state_t st_d;
    dcgm_fault_t flt_q;
    dcgm_fault_t flt_d;
    logic [SW-1:0] short_q;
    logic [SW-1:0] short_d;
    logic [DW-1:0] disc_q;
    logic [DW-1:0] disc_d;
    logic        out_q;
    logic        out_d;
    logic        ren_q;
    logic        ren_d;
    logic        ref_q;
    logic        ref_d;

    dcgm_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb_a (
        .clk        (clk),
        .resetn     (resetn),
        .raw_closed (chan_in.ch_a),
        .closed     (deb.ch_a)
    );
    dcgm_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb_b (
        .clk        (clk),
        .resetn     (resetn),
        .raw_closed (chan_in.ch_b),
        .closed     (deb.ch_b)
    );

    // In complementary mode channel B is inverted so both read closed on run.
    // combined channel state
    assign a_closed    = deb.ch_a;
    assign b_closed    = compl_mode ? !deb.ch_b : deb.ch_b;
    assign guard_run   = a_closed && b_closed;
    assign any_open    = !a_closed || !b_closed;
    assign both_open   = !a_closed && !b_closed;
    assign both_closed = guard_run;

    always_comb begin
        st_d    = st_q;
        flt_d   = flt_q;
        short_d = '0;
        disc_d  = '0;
        ref_d   = 1'b0;
        if (a_closed != b_closed) begin
            if (disc_q >= DW'(DISC_CYCLES - 1)) begin
                flt_d.discrepancy = 1'b1;
                disc_d = disc_q;
            end else begin
                disc_d = disc_q + DW'(1);
            end
        end
        if (compl_mode && (deb.ch_a == deb.ch_b)) begin
            flt_d.compl_loss = 1'b1;
        end
        if (!compl_mode && guard_run && open_window) begin
            if (short_q >= SW'(SHORT_CYCLES - 1)) begin
                flt_d.short_chan = 1'b1;
                short_d = short_q;
            end else begin
                short_d = short_q + SW'(1);
            end
        end
        case (st_q)
            DCGM_ST_STOP: begin
                // interlock armed after reset
                // The filters read open straight after reset, so that reading
                // must never count as an opening of the guard.
                st_d = DCGM_ST_WAIT_OPEN;
            end
            DCGM_ST_WAIT_OPEN: begin
                if (both_open) begin
                    st_d = DCGM_ST_WAIT_CLOSE;
                end else if (reset_req) begin
                    ref_d = 1'b1;
                end
            end
            DCGM_ST_WAIT_CLOSE: begin
                if (both_closed) begin
                    st_d  = DCGM_ST_READY;
                    flt_d = '0;
                end else if (reset_req) begin
                    ref_d = 1'b1;
                end
            end
            DCGM_ST_READY: begin
                if (any_open) begin
                    st_d = both_open ? DCGM_ST_WAIT_CLOSE : DCGM_ST_WAIT_OPEN;
                end else if ((reset_req || auto_reset) && (flt_q == '0)) begin
                    st_d = DCGM_ST_RUN;
                end
            end
            DCGM_ST_RUN: begin
                if (any_open) begin
                    st_d = both_open ? DCGM_ST_WAIT_CLOSE : DCGM_ST_WAIT_OPEN;
                end
            end
            default: begin
                st_d = DCGM_ST_STOP;
            end
        endcase
        if (flt_d != '0 && (st_d == DCGM_ST_RUN || st_d == DCGM_ST_READY)) begin
            st_d = DCGM_ST_WAIT_OPEN;
        end
        out_d = (st_d == DCGM_ST_RUN);
        ren_d = (st_d == DCGM_ST_READY);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q    <= DCGM_ST_STOP;
            flt_q   <= '0;
            short_q <= '0;
            disc_q  <= '0;
            out_q   <= 1'b0;
            ren_q   <= 1'b0;
            ref_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            flt_q   <= flt_d;
            short_q <= short_d;
            disc_q  <= disc_d;
            out_q   <= out_d;
            ren_q   <= ren_d;
            ref_q   <= ref_d;
        end
    end

    assign safety_output_switch = out_q;
    assign fault                = flt_q;
    assign reset_enabled        = ren_q;
    assign reset_refused        = ref_q;

    sequence s_cycle_done;
        (st_q == DCGM_ST_WAIT_CLOSE) && both_closed;
    endsequence

    a_out_open_off: assert property (@(posedge clk) disable iff (!resetn)
        any_open |=> !safety_output_switch)
        else $error("Output stayed on with a channel open.");
    a_out_needs_run: assert property (@(posedge clk) disable iff (!resetn)
        safety_output_switch |-> (st_q == DCGM_ST_RUN))
        else $error("Output on outside run state.");
    a_refuse_no_cycle: assert property (@(posedge clk) disable iff (!resetn)
        (st_q == DCGM_ST_WAIT_OPEN && !both_open && reset_req) |=> reset_refused)
        else $error("Reset not refused before both channels opened.");
    a_cycle_accept: assert property (@(posedge clk) disable iff (!resetn)
        s_cycle_done |=> (fault == '0) && (st_q == DCGM_ST_READY))
        else $error("Completed cycle did not enable reset.");
    a_compl_fault: assert property (@(posedge clk) disable iff (!resetn)
        (compl_mode && deb.ch_a == deb.ch_b) |=> fault.compl_loss || st_q == DCGM_ST_READY)
        else $error("Complementary loss not flagged.");
    a_disc_flag: assert property (@(posedge clk) disable iff (!resetn)
        (disc_q == DW'(DISC_CYCLES - 1) && a_closed != b_closed) |=> fault.discrepancy
            || st_q == DCGM_ST_READY)
        else $error("Discrepancy not flagged.");
    a_short_flag: assert property (@(posedge clk) disable iff (!resetn)
        (short_q == SW'(SHORT_CYCLES - 1) && !compl_mode && guard_run && open_window)
            |=> fault.short_chan)
        else $error("Channel short not flagged.");
    a_run_after_ready: assert property (@(posedge clk) disable iff (!resetn)
        $rose(safety_output_switch) |-> $past(st_q) == DCGM_ST_READY)
        else $error("Run entered without ready state.");
    a_stop_arms_lock: assert property (@(posedge clk) disable iff (!resetn)
        (st_q == DCGM_ST_STOP) |=> (st_q == DCGM_ST_WAIT_OPEN) && !reset_enabled)
        else $error("Stop state did not arm the reset interlock.");
endmodule : dcgm_monitor

//--- src/dcgm_params.svh
// Constants for the dual-channel guard monitor.
`ifndef DCGM_PARAMS_SVH
`define DCGM_PARAMS_SVH
`define DCGM_CLK_HZ            40000000
`define DCGM_SHORT_TIME_MS     2000
`define DCGM_SHORT_CYCLES      ((`DCGM_CLK_HZ / 1000) * `DCGM_SHORT_TIME_MS)
`define DCGM_BASE_RESP_US      10000
`define DCGM_DEB_DEFAULT_US    6000
`define DCGM_DEB_CYCLES        ((`DCGM_CLK_HZ / 1000000) * `DCGM_DEB_DEFAULT_US)
`define DCGM_RESP_CYCLES       ((`DCGM_CLK_HZ / 1000000) * `DCGM_BASE_RESP_US)
`define DCGM_MODE_EQUAL        1'b0
`define DCGM_MODE_COMPL        1'b1
`endif

//--- src/dcgm_pkg.sv
// Types shared by the dual-channel guard monitor.
package dcgm_pkg;
    typedef enum logic [2:0] {
        DCGM_ST_STOP,
        DCGM_ST_WAIT_OPEN,
        DCGM_ST_WAIT_CLOSE,
        DCGM_ST_READY,
        DCGM_ST_RUN
    } dcgm_state_t;

    typedef struct packed {
        logic ch_a;
        logic ch_b;
    } dcgm_chan_t;

    typedef struct packed {
        logic discrepancy;
        logic compl_loss;
        logic short_chan;
    } dcgm_fault_t;
endpackage : dcgm_pkg

//--- src/dcgm_debounce.sv
// Closed-to-open debounce filter for one contact channel.
`timescale 1ns/1ps
module dcgm_debounce #(
    parameter int DEB_CYCLES = 240000
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic raw_closed,
    output logic      closed
);
    localparam int CW = $clog2(DEB_CYCLES + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          closed_q;
    logic          closed_d;

    // Closing is taken at once, opening only after the debounce time, so outside
    // complementary mode a longer debounce lengthens the stop response by exactly the excess.
    always_comb begin
        cnt_d    = '0;
        closed_d = closed_q;
        if (raw_closed) begin
            closed_d = 1'b1;
        end else if (closed_q) begin
            if (cnt_q >= CW'(DEB_CYCLES - 1)) begin
                closed_d = 1'b0;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q    <= '0;
            closed_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            closed_q <= closed_d;
        end
    end

    assign closed = closed_q;
endmodule : dcgm_debounce

//--- bench/dcgm_guard_model.sv
// Partner model: two guard switch contacts with lag and stuck faults.
`timescale 1ns/1ps
module dcgm_guard_model
    import dcgm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       guard_open,
    input  wire logic       compl_mode,
    input  wire logic [3:0] lag_b,
    input  wire logic       stuck_a,
    input  wire logic       stuck_b,
    output dcgm_chan_t      chan
);
    logic [3:0] cnt_q = 4'h0;
    logic       b_open_q = 1'b0;
    // Channel B trails the guard so a slow contact is exercised too.
    always @(posedge clk) begin
        if (b_open_q == guard_open) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= lag_b) begin
            b_open_q <= guard_open;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    always_comb begin
        chan.ch_a = stuck_a | ~guard_open;
        chan.ch_b = stuck_b | (compl_mode ? b_open_q : ~b_open_q);
    end
endmodule : dcgm_guard_model

//--- bench/tb_dcgm_monitor.sv
// Self-checking bench for the dual-channel guard monitor.
`timescale 1ns/1ps
module tb_dcgm_monitor;
    import dcgm_pkg::*;
    localparam int DEB = 4;
    localparam int SHORT = 20;
    localparam int DISC = 8;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        compl_mode = 1'b0;
    logic        auto_reset = 1'b0;
    logic        reset_req = 1'b0;
    logic        open_window = 1'b0;
    logic        guard_open = 1'b0;
    logic        stuck_a = 1'b0;
    logic        stuck_b = 1'b0;
    logic [3:0]  lag_b = 4'h0;
    dcgm_chan_t  chan_in;
    dcgm_fault_t fault;
    logic        safety_output_switch;
    logic        reset_enabled;
    logic        reset_refused;
    int          num_errors = 0;
    int          compares = 0;
    always #12.5 clk = ~clk;
    dcgm_guard_model i_dcgm_guard_model (.clk(clk), .guard_open(guard_open),
        .compl_mode(compl_mode), .lag_b(lag_b), .stuck_a(stuck_a), .stuck_b(stuck_b),
        .chan(chan_in));
    dcgm_monitor #(.DEB_CYCLES(DEB), .SHORT_CYCLES(SHORT), .DISC_CYCLES(DISC)) i_dcgm_monitor (
        .clk(clk), .resetn(resetn), .compl_mode(compl_mode), .auto_reset(auto_reset),
        .reset_req(reset_req), .open_window(open_window), .chan_in(chan_in),
        .safety_output_switch(safety_output_switch), .fault(fault),
        .reset_enabled(reset_enabled), .reset_refused(reset_refused));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic check_bit(input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_bit
    task automatic check_fault(input dcgm_fault_t exp, input dcgm_fault_t got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_fault
    function automatic dcgm_fault_t exp_fault(input logic d, input logic l, input logic s);
        return '{discrepancy: d, compl_loss: l, short_chan: s};
    endfunction : exp_fault
    function automatic logic probe(input int which);
        case (which)
            0: return safety_output_switch;
            1: return reset_enabled;
            2: return reset_refused;
            default: return fault.compl_loss;
        endcase
    endfunction : probe
    // Waits are bounded; running out shows up as a mismatch.
    task automatic wait_out(input int which, input logic val, input int limit);
        int n;
        n = 0;
        while (probe(which) !== val && n < limit) begin
            step(1);
            n++;
        end
        check_bit(val, probe(which));
    endtask : wait_out
    task automatic cycle_guard();
        guard_open = 1'b1;
        step(DEB + 6 + int'(lag_b));
        guard_open = 1'b0;
        step(DEB + 6 + int'(lag_b));
    endtask : cycle_guard
    task automatic run_up();
        reset_req = 1'b1;
        step(1);
        reset_req = 1'b0;
        wait_out(0, 1'b1, 4);
    endtask : run_up
    task automatic do_reset();
        resetn = 1'b0;
        step(2);
        resetn = 1'b1;
    endtask : do_reset
    task automatic complete_run();
        $display("num_errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        #(25 * 4000);
        num_errors++;
        complete_run();
    end
    initial begin
        void'($urandom(54666));
        step(12);
        resetn = 1'b1;
        check_bit(1'b0, safety_output_switch);
        check_bit(1'b0, reset_enabled);
        for (int i = 0; i < 4; i++) begin
            lag_b = 4'($urandom_range(0, 3));
            auto_reset = (i == 2);
            cycle_guard();
            if (i == 2) begin
                check_bit(1'b1, safety_output_switch);
                check_bit(1'b0, reset_enabled);
            end else begin
                wait_out(1, 1'b1, 8);
            end
            check_fault(exp_fault(1'b0, 1'b0, 1'b0), fault);
            if (i != 2) begin
                run_up();
            end
        end
        auto_reset = 1'b0;
        stuck_a = 1'b1;
        guard_open = 1'b1;
        wait_out(0, 1'b0, DEB + 4 + int'(lag_b));
        step(DEB + DISC + 6);
        check_fault(exp_fault(1'b1, 1'b0, 1'b0), fault);
        guard_open = 1'b0;
        step(DEB + 6);
        reset_req = 1'b1;
        wait_out(2, 1'b1, 4);
        reset_req = 1'b0;
        step(2);
        check_bit(1'b0, safety_output_switch);
        check_bit(1'b0, reset_enabled);
        stuck_a = 1'b0;
        cycle_guard();
        wait_out(1, 1'b1, 8);
        check_fault(exp_fault(1'b0, 1'b0, 1'b0), fault);
        run_up();
        do_reset();
        check_bit(1'b0, safety_output_switch);
        step(4);
        check_bit(1'b0, reset_enabled);
        compl_mode = 1'b1;
        do_reset();
        cycle_guard();
        wait_out(1, 1'b1, 8);
        run_up();
        stuck_b = 1'b1;
        wait_out(0, 1'b0, DEB + 4);
        wait_out(3, 1'b1, 4);
        stuck_b = 1'b0;
        compl_mode = 1'b0;
        do_reset();
        open_window = 1'b1;
        step(SHORT - 4);
        check_bit(1'b0, fault.short_chan);
        step(10);
        check_bit(1'b1, fault.short_chan);
        complete_run();
    end
endmodule : tb_dcgm_monitor
